// file: cdd_defs.svh
// Opcode patterns, polynomials, reset values and timing counts for the
// CRC and deinterleave datapath. Definitions only; included by bare name.
`ifndef CDD_DEFS_SVH
`define CDD_DEFS_SVH

// CRC accumulate, byte forms share the lower word
`define CDD_LSW_CRC_P2      16'he2cb
`define CDD_MSW_CRC_P2L     8'h03
`define CDD_MSW_CRC_P2H     8'h04
`define CDD_LSW_CRC_CLR     16'he524
`define CDD_LSW_CRC_STORE   16'he206
`define CDD_LSW_CRC_LOAD    16'he3f6
`define CDD_MSW_CRC_MOVE    8'h00

// Generator polynomials
`define CDD_POLY_P2L        32'h04c11db7
`define CDD_POLY_P2H        32'h1edc6f41

// Deinterleave group
`define CDD_LSW_DIVIDE_ZERO_FLAG_CLR    16'he520
`define CDD_LSW_INCDEC      16'he6f2
`define CDD_MSW_INCDEC      12'h0b0
`define CDD_LSW_INCDEC_LD   16'he281
`define CDD_MSW_INCDEC_LD   1'h0
`define CDD_LSW_MOD         16'he680
`define CDD_MSW_MOD         7'h14

// Reset values
`define CDD_CRC_RESET       32'h0000_0000
`define CDD_DIVIDE_ZERO_FLAG_RESET      1'h0
`define CDD_VR_RESET        32'h0000_0000

// Modulo timing: issue cycle plus eight delay slots
`define CDD_MOD_CYCLES      9
`define CDD_MOD_LAST_ITER   4'h7
`define CDD_MOD_DONE_DELAY  7

`endif

// file: cdd_pkg.sv
// Types shared by the CRC and deinterleave datapath.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package cdd_pkg;

    typedef enum logic [3:0] {
        CDD_OP_NONE     = 4'h0,
        CDD_OP_CRC_LO   = 4'h1,
        CDD_OP_CRC_HI   = 4'h2,
        CDD_OP_CRC_CLR  = 4'h3,
        CDD_OP_CRC_ST   = 4'h4,
        CDD_OP_CRC_LD   = 4'h5,
        CDD_OP_DIVIDE_ZERO_FLAG_CLR = 4'h6,
        CDD_OP_INC      = 4'h7,
        CDD_OP_DEC      = 4'h8,
        CDD_OP_INC_LD   = 4'h9,
        CDD_OP_DEC_LD   = 4'ha,
        CDD_OP_MOD      = 4'hb
    } cdd_op_e;

    typedef enum logic {
        CDD_MOD_IDLE = 1'h0,
        CDD_MOD_RUN  = 1'h1
    } cdd_mod_st_e;

    typedef logic [2:0] cdd_reg_idx_t;

endpackage

`default_nettype wire

// file: cdd_mod_if.sv
// Carrier between the datapath and its modulo unit.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
`default_nettype none

interface cdd_mod_if;
    logic                  start;
    logic [31:0]           dividend;
    logic [15:0]           divisor;
    cdd_pkg::cdd_reg_idx_t dest;
    logic                  done;
    logic [15:0]           rem;
    cdd_pkg::cdd_reg_idx_t rem_dest;

    modport ctl  (output start, dividend, divisor, dest,
                  input  done, rem, rem_dest);
    modport unit (input  start, dividend, divisor, dest,
                  output done, rem, rem_dest);
endinterface

`default_nettype wire

// file: cdd_crc_step.sv
// One byte step of a 32-bit CRC, most significant bit first.
// Purely combinational; the caller registers the result.
`timescale 1ns/10ps
`default_nettype none

module cdd_crc_step #(
    parameter logic [31:0] POLY = 32'h04c11db7
) (
    input  wire logic [31:0] crc_in,
    input  wire logic [7:0]  data_in,
    output logic      [31:0] crc_out
);
    always_comb begin
        logic [31:0] c;
        c = crc_in ^ {data_in, 24'h0};
        for (int i = 0; i < 8; i++) begin
            c = c[31] ? ({c[30:0], 1'b0} ^ POLY) : {c[30:0], 1'b0};
        end
        crc_out = c;
    end
endmodule // cdd_crc_step

`default_nettype wire

// file: cdd_mod_unit.sv
// Signed 32-bit by unsigned 16-bit remainder, four bits per cycle.
// Expects no new start while busy; such a start is dropped.
`timescale 1ns/10ps
`include "cdd_defs.svh"
`default_nettype none

module cdd_mod_unit (
    input  wire logic mclk,
    input  wire logic rst_n,
    cdd_mod_if.unit   mif
);
    cdd_pkg::cdd_mod_st_e state;
    logic [3:0]           iter;
    logic [31:0]          shreg;
    logic [16:0]          part;
    logic [15:0]          dvs;
    logic                 neg;
    cdd_pkg::cdd_reg_idx_t dst;
    logic [31:0]          abs_in;
    logic [16:0]          first_part;
    logic [16:0]          next_part;

    function automatic logic [16:0] step4(input logic [16:0] r_in,
                                          input logic [3:0]  bits,
                                          input logic [15:0] d);
        logic [16:0] r;
        r = r_in;
        for (int i = 3; i >= 0; i--) begin
            r = {r[15:0], bits[i]};
            if (r >= {1'b0, d}) begin
                r = r - {1'b0, d};
            end
        end
        return r;
    endfunction

    // First nibble is consumed at issue so the write lands after 8 slots
    always_comb begin
        abs_in     = mif.dividend[31] ? 32'(32'h0 - mif.dividend)
                                      : mif.dividend;
        first_part = step4(17'h0, abs_in[31:28], mif.divisor);
        next_part  = step4(part, shreg[31:28], dvs);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= cdd_pkg::CDD_MOD_IDLE;
            iter  <= 4'h0;
            shreg <= 32'h0;
            part  <= 17'h0;
            dvs   <= 16'h0;
            neg   <= 1'b0;
            dst   <= 3'h0;
        end else begin
            case (state)
                cdd_pkg::CDD_MOD_IDLE: begin
                    if (mif.start) begin
                        state <= cdd_pkg::CDD_MOD_RUN;
                        iter  <= 4'h1;
                        part  <= first_part;
                        shreg <= {abs_in[27:0], 4'h0};
                        dvs   <= mif.divisor;
                        neg   <= mif.dividend[31];
                        dst   <= mif.dest;
                    end
                end
                default: begin
                    part  <= next_part;
                    shreg <= {shreg[27:0], 4'h0};
                    iter  <= 4'(iter + 4'h1);
                    if (iter == `CDD_MOD_LAST_ITER) begin
                        state <= cdd_pkg::CDD_MOD_IDLE;
                    end
                end
            endcase
        end
    end

    // Remainder takes the dividend's sign
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mif.done     <= 1'b0;
            mif.rem      <= 16'h0;
            mif.rem_dest <= 3'h0;
        end else begin
            mif.done <= (state == cdd_pkg::CDD_MOD_RUN) &&
                        (iter == `CDD_MOD_LAST_ITER);
            if ((state == cdd_pkg::CDD_MOD_RUN) &&
                (iter == `CDD_MOD_LAST_ITER)) begin
                mif.rem      <= neg ? 16'(16'h0 - next_part[15:0])
                                    : next_part[15:0];
                mif.rem_dest <= dst;
            end
        end
    end
endmodule // cdd_mod_unit

`default_nettype wire

// file: cdd_datapath.sv
// CRC and deinterleave execution datapath of an extension coprocessor.
// Assumes the pipeline presents one decoded opcode pair per cycle with
// its memory operand already fetched, on the same clock and reset.
`timescale 1ns/10ps
`include "cdd_defs.svh"
`default_nettype none

// Notes on behaviour
// - Decode low-byte polynomial-2 CRC32 accumulate
// - Low-byte form uses 0x04C11DB7 on LSB
// - Bit reverse select flips the source byte
// - Full 32-bit accumulator updated from byte
// - CRC ops single cycle, flags untouched
// - Clear opcode zeroes CRC accumulator
// - Store opcode writes accumulator to memory
// - Load opcode fills accumulator from memory
// - Dedicated opcode clears divide-zero flag
// - Decode decrement of selected low half
// - Decode increment of selected low half
// - Decrement with parallel 32-bit register load
// - Increment with parallel 32-bit register load
// - Inc/dec single cycle, flags untouched
// - Decode modulo and its three register fields
// - Signed dividend, unsigned divisor, remainder high
// - Zero divisor sets flag, no write
// - Modulo result after eight delay slots
// - Register fields reach registers zero to seven
// - High-byte form uses 0x1EDC6F41 on MSB
module cdd_datapath (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        op_valid,
    input  wire logic [15:0] op_lsw,
    input  wire logic [15:0] op_msw,
    input  wire logic [31:0] mem_rdata,
    input  wire logic        crc_bit_reverse_select,
    input  wire logic [2:0]  reg_rd_sel,
    output logic             mem_we,
    output logic      [31:0] mem_wdata,
    output logic      [31:0] crc_accumulator,
    output logic             divide_zero_flag,
    output logic      [31:0] reg_rd_data,
    output logic             mod_busy
);
    cdd_mod_if             mif ();
    cdd_pkg::cdd_op_e      op;
    logic [31:0]           vr [8];
    logic [31:0]           next_vr [8];
    logic [31:0]           next_crc;
    logic [31:0]           crc_lo_out;
    logic [31:0]           crc_hi_out;
    logic [7:0]            src_byte;
    logic [7:0]            feed_byte;
    cdd_pkg::cdd_reg_idx_t lo_idx;
    cdd_pkg::cdd_reg_idx_t ld_idx;
    logic                  mod_zero;

    ////////////////////////////////////////////////////////////////////
    // Opcode decode; unknown patterns fall through as no operation

    always_comb begin
        op = cdd_pkg::CDD_OP_NONE;
        if (!op_valid) begin
            op = cdd_pkg::CDD_OP_NONE;
        end else if (op_lsw == `CDD_LSW_CRC_P2 &&
                     op_msw[15:8] == `CDD_MSW_CRC_P2L) begin
            op = cdd_pkg::CDD_OP_CRC_LO;
        end else if (op_lsw == `CDD_LSW_CRC_P2 &&
                     op_msw[15:8] == `CDD_MSW_CRC_P2H) begin
            op = cdd_pkg::CDD_OP_CRC_HI;
        end else if (op_lsw == `CDD_LSW_CRC_CLR) begin
            op = cdd_pkg::CDD_OP_CRC_CLR;
        end else if (op_lsw == `CDD_LSW_CRC_STORE &&
                     op_msw[15:8] == `CDD_MSW_CRC_MOVE) begin
            op = cdd_pkg::CDD_OP_CRC_ST;
        end else if (op_lsw == `CDD_LSW_CRC_LOAD &&
                     op_msw[15:8] == `CDD_MSW_CRC_MOVE) begin
            op = cdd_pkg::CDD_OP_CRC_LD;
        end else if (op_lsw == `CDD_LSW_DIVIDE_ZERO_FLAG_CLR) begin
            op = cdd_pkg::CDD_OP_DIVIDE_ZERO_FLAG_CLR;
        end else if (op_lsw == `CDD_LSW_INCDEC &&
                     op_msw[15:4] == `CDD_MSW_INCDEC) begin
            op = op_msw[3] ? cdd_pkg::CDD_OP_DEC
                           : cdd_pkg::CDD_OP_INC;
        end else if (op_lsw == `CDD_LSW_INCDEC_LD &&
                     op_msw[15] == `CDD_MSW_INCDEC_LD) begin
            op = op_msw[14] ? cdd_pkg::CDD_OP_DEC_LD
                            : cdd_pkg::CDD_OP_INC_LD;
        end else if (op_lsw == `CDD_LSW_MOD &&
                     op_msw[15:9] == `CDD_MSW_MOD) begin
            op = cdd_pkg::CDD_OP_MOD;
        end
    end

    // Three-bit fields cannot name a ninth register
    always_comb begin
        lo_idx = (op == cdd_pkg::CDD_OP_INC_LD ||
                  op == cdd_pkg::CDD_OP_DEC_LD) ? op_msw[10:8]
                                                : op_msw[2:0];
        ld_idx = op_msw[13:11];
    end

    ////////////////////////////////////////////////////////////////////
    // CRC accumulator

    always_comb begin
        src_byte = (op == cdd_pkg::CDD_OP_CRC_HI) ? mem_rdata[15:8]
                                                 : mem_rdata[7:0];
        for (int i = 0; i < 8; i++) begin
            feed_byte[i] = crc_bit_reverse_select ? src_byte[7 - i]
                                                  : src_byte[i];
        end
    end

    cdd_crc_step #(.POLY(`CDD_POLY_P2L)) u_crc_lo (
        .crc_in  (crc_accumulator),
        .data_in (feed_byte),
        .crc_out (crc_lo_out)
    );

    cdd_crc_step #(.POLY(`CDD_POLY_P2H)) u_crc_hi (
        .crc_in  (crc_accumulator),
        .data_in (feed_byte),
        .crc_out (crc_hi_out)
    );

    always_comb begin
        case (op)
            cdd_pkg::CDD_OP_CRC_LO:  next_crc = crc_lo_out;
            cdd_pkg::CDD_OP_CRC_HI:  next_crc = crc_hi_out;
            cdd_pkg::CDD_OP_CRC_CLR: next_crc = `CDD_CRC_RESET;
            cdd_pkg::CDD_OP_CRC_LD:  next_crc = mem_rdata;
            default:                 next_crc = crc_accumulator;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            crc_accumulator <= `CDD_CRC_RESET;
        end else begin
            crc_accumulator <= next_crc;
        end
    end

    // Store hands the accumulator out one cycle after the opcode
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mem_we    <= 1'b0;
            mem_wdata <= 32'h0;
        end else begin
            mem_we <= (op == cdd_pkg::CDD_OP_CRC_ST);
            if (op == cdd_pkg::CDD_OP_CRC_ST) begin
                mem_wdata <= crc_accumulator;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Divide-by-zero flag; only modulo issue sets it, only its clear
    // opcode clears it, and the set is tested first

    assign mod_zero = (op == cdd_pkg::CDD_OP_MOD) &&
                      (vr[op_msw[2:0]][31:16] == 16'h0);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            divide_zero_flag <= `CDD_DIVIDE_ZERO_FLAG_RESET;
        end else if (mod_zero) begin
            divide_zero_flag <= 1'b1;
        end else if (op == cdd_pkg::CDD_OP_DIVIDE_ZERO_FLAG_CLR) begin
            divide_zero_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Modulo unit; a zero divisor never starts it, so no write follows

    always_comb begin
        mif.start    = (op == cdd_pkg::CDD_OP_MOD) && !mod_zero;
        mif.dividend = vr[op_msw[5:3]];
        mif.divisor  = vr[op_msw[2:0]][31:16];
        mif.dest     = op_msw[8:6];
    end

    cdd_mod_unit u_mod (
        .mclk  (mclk),
        .rst_n (rst_n),
        .mif   (mif.unit)
    );

    // Overlap is the pipeline's duty; a second start before the done cycle is lost
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mod_busy <= 1'b0;
        end else if (mif.start && !mod_busy) begin
            mod_busy <= 1'b1;
        end else if (mif.done) begin
            mod_busy <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // General registers; a parallel load outranks a same-register step

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            next_vr[i] = vr[i];
            if (mif.done && mif.rem_dest == 3'(i)) begin
                next_vr[i][31:16] = mif.rem;
            end
            if (lo_idx == 3'(i) && (op == cdd_pkg::CDD_OP_INC ||
                                    op == cdd_pkg::CDD_OP_INC_LD)) begin
                next_vr[i][15:0] = vr[i][15:0] + 16'h0001;
            end
            if (lo_idx == 3'(i) && (op == cdd_pkg::CDD_OP_DEC ||
                                    op == cdd_pkg::CDD_OP_DEC_LD)) begin
                next_vr[i][15:0] = vr[i][15:0] - 16'h0001;
            end
            if (ld_idx == 3'(i) && (op == cdd_pkg::CDD_OP_INC_LD ||
                                    op == cdd_pkg::CDD_OP_DEC_LD)) begin
                next_vr[i] = mem_rdata;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 8; i++) begin
                vr[i] <= `CDD_VR_RESET;
            end
            reg_rd_data <= `CDD_VR_RESET;
        end else begin
            for (int i = 0; i < 8; i++) begin
                vr[i] <= next_vr[i];
            end
            reg_rd_data <= vr[reg_rd_sel];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks

    logic [15:0] chk_lo;
    logic [15:0] chk_hi;
    logic [2:0]  chk_idx;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            chk_lo  <= 16'h0;
            chk_hi  <= 16'h0;
            chk_idx <= 3'h0;
        end else begin
            chk_lo  <= vr[op_msw[2:0]][15:0];
            chk_hi  <= vr[op_msw[2:0]][31:16];
            chk_idx <= op_msw[2:0];
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_crc_clear_zero: assert property (
        op == cdd_pkg::CDD_OP_CRC_CLR |=> crc_accumulator == 32'h0)
        else $error("CRC clear did not zero accumulator");

    a_crc_load_value: assert property (
        op == cdd_pkg::CDD_OP_CRC_LD |=>
            crc_accumulator == $past(mem_rdata))
        else $error("CRC load value wrong");

    a_crc_store_data: assert property (
        op == cdd_pkg::CDD_OP_CRC_ST |=>
            mem_we && mem_wdata == $past(crc_accumulator) ##1
            (!mem_we || $past(op == cdd_pkg::CDD_OP_CRC_ST)))
        else $error("CRC store strobe or data wrong");

    a_crc_flag_kept: assert property (
        (op inside {cdd_pkg::CDD_OP_CRC_LO, cdd_pkg::CDD_OP_CRC_HI,
                    cdd_pkg::CDD_OP_CRC_CLR, cdd_pkg::CDD_OP_CRC_ST,
                    cdd_pkg::CDD_OP_CRC_LD, cdd_pkg::CDD_OP_INC,
                    cdd_pkg::CDD_OP_DEC, cdd_pkg::CDD_OP_INC_LD,
                    cdd_pkg::CDD_OP_DEC_LD}) |=> $stable(divide_zero_flag))
        else $error("Flag changed by a flagless op");

    a_divide_zero_flag_clear_op: assert property (
        op == cdd_pkg::CDD_OP_DIVIDE_ZERO_FLAG_CLR |=> !divide_zero_flag)
        else $error("Divide flag not cleared");

    a_divide_zero_flag_zero_set: assert property (
        mod_zero |=> divide_zero_flag && !mod_busy)
        else $error("Zero divisor not flagged");

    a_divide_zero_flag_flag_sticky: assert property (
        divide_zero_flag && op != cdd_pkg::CDD_OP_DIVIDE_ZERO_FLAG_CLR |=>
            divide_zero_flag)
        else $error("Divide flag dropped on its own");

    a_mod_result_time: assert property (
        mif.start && !mod_busy |-> !mif.done [*8] ##1 mif.done)
        else $error("Remainder not ready after eight slots");

    a_inc_wrap_low: assert property (
        op == cdd_pkg::CDD_OP_INC |=>
            vr[chk_idx][15:0] == 16'(chk_lo + 16'h1) &&
            (vr[chk_idx][31:16] == chk_hi || $past(mif.done)))
        else $error("Low half increment wrong");

    c_crc_low_byte: cover property (op == cdd_pkg::CDD_OP_CRC_LO);
    c_mod_done:     cover property (mif.done);
    c_dec_load:     cover property (op == cdd_pkg::CDD_OP_DEC_LD);
    c_divide_zero_flag_set:     cover property (mod_zero);

endmodule // cdd_datapath

`default_nettype wire

// file: cdd_host_mem.sv
// Data memory model standing behind the datapath's operand and store ports.
// Assumes the bench gives an address and an enable with each opcode.
`timescale 1ns/10ps
`default_nettype none

module cdd_host_mem (
    input  wire logic        mclk,
    input  wire logic        en,
    input  wire logic [3:0]  addr,
    input  wire logic        mem_we,
    input  wire logic [31:0] mem_wdata,
    output logic      [31:0] mem_rdata
);
    logic [31:0] mem [16];
    logic [3:0]  waddr;

    initial for (int i = 0; i < 16; i++) mem[i] = 32'h9e3779b9 * (i + 1);
    // An unselected bus must not look like valid data
    assign mem_rdata = en ? mem[addr] : ~mem[addr];
    // Strobe comes a cycle after the store, so its address is kept
    always @(posedge mclk) begin
        waddr <= addr;
        if (mem_we) mem[waddr] <= mem_wdata;
    end
endmodule // cdd_host_mem

`default_nettype wire

// file: crc_deinterleave_datapath_tb.sv
// Bench for the CRC and deinterleave datapath: random and corner opcodes.
// Assumes cdd_defs.svh, cdd_pkg and cdd_host_mem are compiled first.
`timescale 1ns/10ps
`include "cdd_defs.svh"
`default_nettype none

module crc_deinterleave_datapath_tb;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        op_valid = 1'b0;
    logic [15:0] op_lsw = 16'h0000;
    logic [15:0] op_msw = 16'h0000;
    logic        crc_bit_reverse_select = 1'b0;
    logic [2:0]  reg_rd_sel = 3'h0;
    logic [3:0]  addr = 4'h0;
    logic [31:0] mem_rdata;
    logic [31:0] mem_wdata;
    logic [31:0] crc_accumulator;
    logic [31:0] reg_rd_data;
    logic        mem_we;
    logic        divide_zero_flag;
    logic        mod_busy;
    logic [31:0] crc;
    logic [31:0] vr [8];
    int          n_fail = 0;
    int          n_tests = 0;
    int          seed = 95314;

    always #20 mclk = ~mclk;

    cdd_datapath cdd_datapath_i (.mclk(mclk), .rst_n(rst_n),
        .op_valid(op_valid), .op_lsw(op_lsw), .op_msw(op_msw),
        .mem_rdata(mem_rdata), .reg_rd_sel(reg_rd_sel),
        .crc_bit_reverse_select(crc_bit_reverse_select),
        .mem_we(mem_we), .mem_wdata(mem_wdata),
        .crc_accumulator(crc_accumulator), .reg_rd_data(reg_rd_data),
        .divide_zero_flag(divide_zero_flag), .mod_busy(mod_busy));
    cdd_host_mem cdd_host_mem_i (.mclk(mclk), .en(op_valid), .addr(addr),
        .mem_we(mem_we), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

    ////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        return $random(seed);
    endfunction

    function automatic logic [31:0] crc_step(input logic [31:0] c,
        input logic [7:0] b, input logic rev, input logic [31:0] p);
        logic [7:0] x;
        for (int i = 0; i < 8; i++) x[i] = rev ? b[7-i] : b[i];
        c = c ^ {x, 24'h0};
        for (int i = 0; i < 8; i++) c = c[31] ? (c << 1) ^ p : c << 1;
        return c;
    endfunction

    task automatic tally_and_finish();
        $display("Counts: %0d checks, %0d failed", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time,
                     what, got, exp);
        end
    endtask

    // Opcode is held one cycle; the caller ends a burst with idle or chkreg
    task automatic op(input logic [15:0] l, m, input logic [3:0] ad,
                      output logic [31:0] d);
        op_valid = 1'b1;
        op_lsw = l;
        op_msw = m;
        addr = ad;
        #1 d = mem_rdata;
        @(negedge mclk);
    endtask

    task automatic idle(input int n);
        op_valid = 1'b0;
        repeat (n) @(negedge mclk);
    endtask

    task automatic chkreg(input logic [2:0] i);
        op_valid = 1'b0;
        reg_rd_sel = i;
        @(negedge mclk);
        chk(reg_rd_data, vr[i], "register");
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] d;
        logic [31:0] e;
        logic [2:0]  a;
        logic [2:0]  b;
        logic [2:0]  c;
        logic        dn;
        logic        ld;
        int          x;
        int          y;
        repeat (6) @(negedge mclk);
        chk(crc_accumulator | reg_rd_data, 32'h0, "reset data");
        chk({29'h0, mem_we, divide_zero_flag, mod_busy}, 32'h0, "reset");
        rst_n = 1'b1;
        crc = 32'h0;
        foreach (vr[i]) vr[i] = 32'h0;
        for (int k = 0; k < 24; k++) begin
            d = rnd();
            crc_bit_reverse_select = d[0];
            op(`CDD_LSW_CRC_P2, {d[1] ? `CDD_MSW_CRC_P2H : `CDD_MSW_CRC_P2L,
               d[15:8]}, d[19:16], e);
            crc = crc_step(crc, d[1] ? e[15:8] : e[7:0], d[0],
                           d[1] ? `CDD_POLY_P2H : `CDD_POLY_P2L);
            chk(crc_accumulator, crc, "crc");
        end
        op(`CDD_LSW_CRC_STORE, {`CDD_MSW_CRC_MOVE, 8'h00}, 4'h9, d);
        chk({31'h0, mem_we}, 32'h1, "store strobe");
        chk(mem_wdata, crc, "store data");
        op(`CDD_LSW_CRC_CLR, 16'h0000, 4'h0, d);
        chk({31'h0, mem_we}, 32'h0, "strobe width");
        chk(crc_accumulator, 32'h0, "clear");
        op(`CDD_LSW_CRC_LOAD, {`CDD_MSW_CRC_MOVE, 8'h00}, 4'h9, d);
        chk(crc_accumulator, crc, "reload");
        op(`CDD_LSW_CRC_CLR, 16'h0000, 4'h0, d);
        op(`CDD_LSW_CRC_STORE, {`CDD_MSW_CRC_MOVE, 8'h00}, 4'h5, d);
        chk({31'h0, divide_zero_flag}, 32'h0, "crc flags");
        $display("Test crc done");
        for (int k = 0; k < 40; k++) begin
            d = rnd();
            a = (k < 2) ? 3'h0 : d[2:0];
            b = (k < 2) ? 3'h7 : d[5:3];
            dn = (k == 0) || (k > 1 && d[6]);
            ld = (k > 1 && d[7]);
            if (ld) op(`CDD_LSW_INCDEC_LD, {1'b0, dn, b, a, d[15:8]},
                       d[19:16], e);
            else op(`CDD_LSW_INCDEC, {`CDD_MSW_INCDEC, dn, a}, 4'h0, e);
            vr[a][15:0] = dn ? vr[a][15:0] - 16'h1 : vr[a][15:0] + 16'h1;
            if (ld) vr[b] = e;
            chkreg(a);
            chkreg(b);
        end
        chk({31'h0, divide_zero_flag}, 32'h0, "step flags");
        // Cleared word stored at 5 becomes a zero divisor in vr7
        op(`CDD_LSW_INCDEC_LD, {2'b00, 3'h7, 3'h6, 8'h00}, 4'h5, e);
        vr[6][15:0] = vr[6][15:0] + 16'h1;
        vr[7] = e;
        chk(e, 32'h0, "stored zero");
        $display("Test step done");
        for (int k = 0; k < 8; k++) begin
            d = rnd();
            a = d[2:0];
            b = d[5:3];
            c = (k == 0) ? 3'h7 : d[8:6];
            x = vr[b];
            y = {16'h0, vr[c][31:16]};
            op(`CDD_LSW_MOD, {`CDD_MSW_MOD, a, b, c}, 4'h0, e);
            chk({30'h0, mod_busy, divide_zero_flag}, (y != 0) ? 32'h2 :
                32'h1, "mod issue");
            idle(7);
            chk({31'h0, mod_busy}, {31'h0, y != 0}, "busy");
            idle(1);
            chk({31'h0, mod_busy}, 32'h0, "busy end");
            if (y != 0) vr[a][31:16] = 16'(x % y);
            chkreg(a);
            op(`CDD_LSW_CRC_CLR, 16'h0000, 4'h0, d);
            // A step while the flag may be up must leave it alone
            op(`CDD_LSW_INCDEC, {`CDD_MSW_INCDEC, 1'b0, c}, 4'h0,
               d);
            vr[c][15:0] = vr[c][15:0] + 16'h1;
            chk({31'h0, divide_zero_flag}, {31'h0, y == 0}, "sticky");
            op(`CDD_LSW_DIVIDE_ZERO_FLAG_CLR, 16'h0000, 4'h0, d);
            chk({31'h0, divide_zero_flag}, 32'h0, "flag clear");
        end
        idle(1);
        $display("Test modulo done");
        tally_and_finish();
    end

    initial begin
        #(40 * 4000);
        n_fail++;
        tally_and_finish();
    end
endmodule // crc_deinterleave_datapath_tb

`default_nettype wire
